// *** frm_pkg.sv ***
package frm_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_PROCESS_SELECTION_OFFSET = 8'h0C;
  localparam logic [7:0] IDX_FUNCTION_OUTCOME         = 8'h0E;
  localparam logic [7:0] IDX_FUNCTION_CODE            = 8'h10;
  localparam logic [7:0] IDX_MAP_ENTRY_SELECTOR       = 8'h12;
  localparam logic [7:0] IDX_MAP_ENTRY_CONFIG         = 8'h14;
  localparam logic [7:0] IDX_SUBRANGE_START           = 8'h16;
  localparam logic [7:0] IDX_SUBRANGE_SIZE_MASK       = 8'h18;
  localparam logic [7:0] IDX_SEGMENT_DESCRIPTOR_REF   = 8'h1A;
  localparam logic [7:0] IDX_SEGMENT_START_OFFSET     = 8'h1C;
  localparam logic [7:0] IDX_TRANSFER_BYTE_COUNT      = 8'h1E;
  localparam logic [7:0] IDX_UNIT_CONTROL             = 8'h40;
  localparam logic [7:0] IDX_PROCESS_LIST_BASE        = 8'h41;
  localparam logic [7:0] IDX_PROCESS_ENVIRONMENT      = 8'h42;
  localparam logic [7:0] IDX_MAP_STATUS               = 8'h43;
  localparam logic [7:0] IDX_DESCRIPTOR_INDEX         = 8'h44;
  localparam logic [7:0] IDX_DESCRIPTOR_DATA          = 8'h45;
  localparam int         IDX_TO_BYTE_SHIFT            = 2;

  // function codes handled here
  localparam logic [7:0] CODE_ALTER_MAP      = 8'h00;
  localparam logic [7:0] CODE_AMPLIFY_RIGHTS = 8'h08;

  // function outcome values
  localparam logic [15:0] OUTCOME_CLEAR       = 16'h0000;
  localparam logic [15:0] OUTCOME_BUSY        = 16'h0001;
  localparam logic [15:0] OUTCOME_DONE        = 16'h0002;
  localparam logic [15:0] OUTCOME_BAD_ENTRY   = 16'h0003;
  localparam logic [15:0] OUTCOME_BAD_CODE    = 16'h0004;

  // unit control fields
  localparam int CTRL_PHYSICAL_MODE_BIT = 0;
  localparam int CTRL_DONE_IRQ_EN_BIT   = 1;
  localparam logic [1:0] CTRL_RESET     = 2'h2;

  // map entry config fields
  localparam int CFG_VALID_BIT    = 0;
  localparam int CFG_BLOCK_XFER_BIT = 1;

  // map entries: 0..3 logical, 0..4 physical
  localparam int          MAP_ENTRIES        = 5;
  localparam logic [15:0] LAST_LOGICAL_ENTRY  = 16'h0003;
  localparam logic [15:0] LAST_PHYSICAL_ENTRY = 16'h0004;
  localparam int          PHYS_ADDR_BITS      = 24;
  localparam int          DESC_ENTRIES        = 16;

  typedef enum logic [1:0] {
    FRM_IDLE   = 2'b00,
    FRM_DECODE = 2'b01,
    FRM_APPLY  = 2'b10,
    FRM_FINISH = 2'b11
  } frm_state_t;

endpackage

// *** frm_function_request.sv ***
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module frm_function_request (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             completion_irq,
  output logic [4:0]       entry_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] process_selection_offset;
  logic [15:0] function_outcome;
  logic [7:0]  function_code;
  logic [15:0] map_entry_selector;
  logic [15:0] map_entry_config;
  logic [15:0] subrange_start;
  logic [15:0] subrange_size_mask;
  logic [15:0] segment_descriptor_ref;
  logic [15:0] segment_start_offset;
  logic [15:0] transfer_byte_count;
  logic [1:0]  unit_control;
  logic [15:0] process_list_base;
  logic [15:0] process_environment;
  logic [3:0]  descriptor_index;

  // per map entry state
  logic [15:0] ent_config     [frm_pkg::MAP_ENTRIES];
  logic [15:0] ent_start      [frm_pkg::MAP_ENTRIES];
  logic [15:0] ent_mask       [frm_pkg::MAP_ENTRIES];
  logic [15:0] ent_displace   [frm_pkg::MAP_ENTRIES];
  logic [15:0] ent_count      [frm_pkg::MAP_ENTRIES];
  logic [23:0] ent_phys_base  [frm_pkg::MAP_ENTRIES];
  logic [15:0] mapped_segment [frm_pkg::MAP_ENTRIES];
  logic [15:0] descriptor     [frm_pkg::DESC_ENTRIES];

  frm_pkg::frm_state_t state;
  frm_pkg::frm_state_t next_state;

  logic        wr_access;
  logic        rd_setup;
  logic [7:0]  reg_idx;
  logic        idx_mapped;
  logic        launch;
  logic        physical_mode;
  logic [2:0]  entry;
  logic        entry_ok;
  logic        apply_map;
  logic        apply_rights;
  logic [15:0] exec_outcome;
  logic        outcome_write;
  logic        done_irq_due;
  logic        irq_due_q;
  logic [15:0] amplified;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic idx_known(input logic [7:0] idx);
    unique case (idx)
      frm_pkg::IDX_PROCESS_SELECTION_OFFSET,
      frm_pkg::IDX_FUNCTION_OUTCOME,
      frm_pkg::IDX_FUNCTION_CODE,
      frm_pkg::IDX_MAP_ENTRY_SELECTOR,
      frm_pkg::IDX_MAP_ENTRY_CONFIG,
      frm_pkg::IDX_SUBRANGE_START,
      frm_pkg::IDX_SUBRANGE_SIZE_MASK,
      frm_pkg::IDX_SEGMENT_DESCRIPTOR_REF,
      frm_pkg::IDX_SEGMENT_START_OFFSET,
      frm_pkg::IDX_TRANSFER_BYTE_COUNT,
      frm_pkg::IDX_UNIT_CONTROL,
      frm_pkg::IDX_PROCESS_LIST_BASE,
      frm_pkg::IDX_PROCESS_ENVIRONMENT,
      frm_pkg::IDX_MAP_STATUS,
      frm_pkg::IDX_DESCRIPTOR_INDEX,
      frm_pkg::IDX_DESCRIPTOR_DATA: idx_known = 1'b1;
      default: idx_known = 1'b0;
    endcase
  endfunction

  function automatic logic is_write_to(input logic [7:0] idx);
    is_write_to = wr_access && idx_mapped && (reg_idx == idx);
  endfunction

  assign reg_idx    = paddr[9:2];
  // low address bits and bits above the index must be clear
  assign idx_mapped = idx_known(reg_idx) && (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign wr_access  = psel && penable && pready && pwrite;
  assign rd_setup   = psel && !penable && !pwrite;
  assign physical_mode = unit_control[frm_pkg::CTRL_PHYSICAL_MODE_BIT];
  assign launch     = is_write_to(frm_pkg::IDX_FUNCTION_CODE) && (state == frm_pkg::FRM_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // bus answer: no wait state, data registered at the setup edge

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !idx_mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      // refused or misaligned reads return zero
      unique case (idx_mapped ? reg_idx : 8'hFF)
        frm_pkg::IDX_PROCESS_SELECTION_OFFSET: prdata[15:0] <= process_selection_offset;
        frm_pkg::IDX_FUNCTION_OUTCOME:         prdata[15:0] <= function_outcome;
        frm_pkg::IDX_FUNCTION_CODE:            prdata[7:0]  <= function_code;
        frm_pkg::IDX_MAP_ENTRY_SELECTOR:       prdata[15:0] <= map_entry_selector;
        frm_pkg::IDX_MAP_ENTRY_CONFIG:         prdata[15:0] <= map_entry_config;
        frm_pkg::IDX_SUBRANGE_START:           prdata[15:0] <= subrange_start;
        frm_pkg::IDX_SUBRANGE_SIZE_MASK:       prdata[15:0] <= subrange_size_mask;
        frm_pkg::IDX_SEGMENT_DESCRIPTOR_REF:   prdata[15:0] <= segment_descriptor_ref;
        frm_pkg::IDX_SEGMENT_START_OFFSET:     prdata[15:0] <= segment_start_offset;
        frm_pkg::IDX_TRANSFER_BYTE_COUNT:      prdata[15:0] <= transfer_byte_count;
        frm_pkg::IDX_UNIT_CONTROL:             prdata[1:0]  <= unit_control;
        frm_pkg::IDX_PROCESS_LIST_BASE:        prdata[15:0] <= process_list_base;
        frm_pkg::IDX_PROCESS_ENVIRONMENT:      prdata[15:0] <= process_environment;
        frm_pkg::IDX_MAP_STATUS:               prdata[4:0]  <= entry_valid;
        frm_pkg::IDX_DESCRIPTOR_INDEX:         prdata[3:0]  <= descriptor_index;
        frm_pkg::IDX_DESCRIPTOR_DATA:          prdata[15:0] <= descriptor[descriptor_index];
        default:                               prdata       <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request facility slots, written only by the host

  // no execution path writes the selection slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      process_selection_offset <= 16'h0000;
    end else if (is_write_to(frm_pkg::IDX_PROCESS_SELECTION_OFFSET)) begin
      process_selection_offset <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_code          <= 8'h00;
      map_entry_selector     <= 16'h0000;
      map_entry_config       <= 16'h0000;
      subrange_start         <= 16'h0000;
      subrange_size_mask     <= 16'h0000;
      segment_descriptor_ref <= 16'h0000;
      segment_start_offset   <= 16'h0000;
      transfer_byte_count    <= 16'h0000;
      unit_control           <= frm_pkg::CTRL_RESET;
      process_list_base      <= 16'h0000;
      descriptor_index       <= 4'h0;
    end else begin
      // only the low byte is the code
      if (is_write_to(frm_pkg::IDX_FUNCTION_CODE)) begin
        function_code <= pwdata[7:0];
      end
      if (is_write_to(frm_pkg::IDX_MAP_ENTRY_SELECTOR)) begin
        map_entry_selector <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_MAP_ENTRY_CONFIG)) begin
        map_entry_config <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_SUBRANGE_START)) begin
        subrange_start <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_SUBRANGE_SIZE_MASK)) begin
        subrange_size_mask <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_SEGMENT_DESCRIPTOR_REF)) begin
        segment_descriptor_ref <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_SEGMENT_START_OFFSET)) begin
        segment_start_offset <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_TRANSFER_BYTE_COUNT)) begin
        transfer_byte_count <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_UNIT_CONTROL)) begin
        unit_control <= pwdata[1:0];
      end
      if (is_write_to(frm_pkg::IDX_PROCESS_LIST_BASE)) begin
        process_list_base <= pwdata[15:0];
      end
      if (is_write_to(frm_pkg::IDX_DESCRIPTOR_INDEX)) begin
        descriptor_index <= pwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // execution sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= frm_pkg::FRM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      frm_pkg::FRM_IDLE:   if (launch) next_state = frm_pkg::FRM_DECODE;
      frm_pkg::FRM_DECODE: next_state = frm_pkg::FRM_APPLY;
      frm_pkg::FRM_APPLY:  next_state = frm_pkg::FRM_FINISH;
      frm_pkg::FRM_FINISH: next_state = frm_pkg::FRM_IDLE;
    endcase
  end

  // process environment is list base plus byte offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      process_environment <= 16'h0000;
    end else if (state == frm_pkg::FRM_DECODE) begin
      process_environment <= 16'(process_list_base + process_selection_offset);
    end
  end

  assign entry = map_entry_selector[2:0];

  assign entry_ok = physical_mode ? (map_entry_selector <= frm_pkg::LAST_PHYSICAL_ENTRY)
                                  : (map_entry_selector <= frm_pkg::LAST_LOGICAL_ENTRY);

  assign apply_map    = (state == frm_pkg::FRM_APPLY) && (function_code == frm_pkg::CODE_ALTER_MAP)
                        && entry_ok;
  assign apply_rights = (state == frm_pkg::FRM_APPLY) && !physical_mode
                        && (function_code == frm_pkg::CODE_AMPLIFY_RIGHTS);

  always_comb begin
    if (function_code == frm_pkg::CODE_ALTER_MAP) begin
      exec_outcome = entry_ok ? frm_pkg::OUTCOME_DONE : frm_pkg::OUTCOME_BAD_ENTRY;
    end else if (function_code == frm_pkg::CODE_AMPLIFY_RIGHTS && !physical_mode) begin
      exec_outcome = frm_pkg::OUTCOME_DONE;
    end else begin
      exec_outcome = frm_pkg::OUTCOME_BAD_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // map entries

  // closing a window keeps the other operands out
  generate
    for (genvar e = 0; e < frm_pkg::MAP_ENTRIES; e++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ent_config[e]     <= 16'h0000;
          ent_start[e]      <= 16'h0000;
          ent_mask[e]       <= 16'h0000;
          ent_displace[e]   <= 16'h0000;
          ent_count[e]      <= 16'h0000;
          ent_phys_base[e]  <= 24'h00_0000;
          mapped_segment[e] <= 16'h0000;
        end else if (apply_map && entry == 3'(e)) begin
          ent_config[e] <= map_entry_config;
          if (map_entry_config[frm_pkg::CFG_VALID_BIT]) begin
            ent_start[e] <= subrange_start;
            ent_mask[e]  <= subrange_size_mask;
            if (physical_mode) begin
              // operand four low, operand five high byte
              ent_phys_base[e] <= {segment_start_offset[7:0], segment_descriptor_ref};
              if (map_entry_config[frm_pkg::CFG_BLOCK_XFER_BIT]) begin
                ent_count[e] <= segment_start_offset;
              end
            end else begin
              mapped_segment[e] <= segment_descriptor_ref;
              ent_displace[e]   <= segment_start_offset;
              // seventh operand only in block transfer
              if (map_entry_config[frm_pkg::CFG_BLOCK_XFER_BIT]) begin
                ent_count[e] <= transfer_byte_count;
              end
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_valid <= 5'h00;
    end else begin
      for (int e = 0; e < frm_pkg::MAP_ENTRIES; e++) begin
        entry_valid[e] <= ent_config[e][frm_pkg::CFG_VALID_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // descriptor table and rights amplification

  // only operands 0 and 1 matter here
  assign amplified = descriptor[map_entry_selector[3:0]] | descriptor[map_entry_config[3:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int d = 0; d < frm_pkg::DESC_ENTRIES; d++) begin
        descriptor[d] <= 16'h0000;
      end
    end else if (apply_rights) begin
      // result overwrites the target in place
      descriptor[map_entry_selector[3:0]] <= amplified;
    end else if (is_write_to(frm_pkg::IDX_DESCRIPTOR_DATA)) begin
      descriptor[descriptor_index] <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outcome and completion interrupt

  assign outcome_write = (state == frm_pkg::FRM_FINISH);

  // hardware update wins over a host write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_outcome <= frm_pkg::OUTCOME_CLEAR;
    end else if (outcome_write) begin
      function_outcome <= exec_outcome;
    end else if (state == frm_pkg::FRM_DECODE) begin
      function_outcome <= frm_pkg::OUTCOME_BUSY;
    end else if (is_write_to(frm_pkg::IDX_FUNCTION_OUTCOME)) begin
      function_outcome <= pwdata[15:0];
    end
  end

  // success interrupt gated, failures always signalled
  assign done_irq_due = outcome_write && ((exec_outcome != frm_pkg::OUTCOME_DONE)
                        || unit_control[frm_pkg::CTRL_DONE_IRQ_EN_BIT]);

  // pulse one cycle after the outcome lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_due_q      <= 1'b0;
      completion_irq <= 1'b0;
    end else begin
      irq_due_q      <= done_irq_due;
      completion_irq <= irq_due_q;
    end
  end

endmodule

// *** frm_function_request_asserts.sv ***
`timescale 1ns/10ps
module frm_function_request_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        completion_irq,
  input wire logic [4:0]  entry_valid
);
  localparam logic [11:0] CODE_ADDR = {2'b00, frm_pkg::IDX_FUNCTION_CODE, 2'b00};
  logic       code_wr;
  logic [3:0] since_code;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign code_wr = psel & penable & pready & pwrite & (paddr == CODE_ADDR);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last accepted code write; saturates at 15
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_code <= 4'hF;
    end else if (code_wr) begin
      since_code <= 4'h1;
    end else if (since_code != 4'hF) begin
      since_code <= since_code + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  ready_timing_a: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  code_byte_a: assert property (pready && !pwrite && paddr == CODE_ADDR
                                |-> prdata[31:8] == 24'h0 && !pslverr)
    else $error("code slot wider than one byte");
  irq_pulse_a: assert property ($rose(completion_irq) |=> !completion_irq)
    else $error("completion pulse longer than one cycle");
  irq_window_a: assert property (completion_irq |-> since_code == 4'h5)
    else $error("completion pulse at the wrong cycle");
  entry_stable_a: assert property (since_code == 4'hF |-> $stable(entry_valid))
    else $error("map entries changed without a request");
  cover property (code_wr);
  cover property (completion_irq);
  cover property (pslverr);
  cover property ($changed(entry_valid));
endmodule
bind frm_function_request frm_function_request_checker frm_function_request_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .completion_irq(completion_irq), .entry_valid(entry_valid)
);

// *** frm_host_model.sv ***
`timescale 1ns/10ps
module frm_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // call just after a rising edge; request held until ready is sampled
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, idx, wd, rd, err);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // offset, cleared outcome, code last
  task automatic request(input logic [15:0] sel, input logic [15:0] op0,
                         input logic [15:0] op1, input logic [31:0] code);
    wr(frm_pkg::IDX_PROCESS_SELECTION_OFFSET, {16'h0, sel});
    wr(frm_pkg::IDX_FUNCTION_OUTCOME, {16'h0, frm_pkg::OUTCOME_CLEAR});
    wr(frm_pkg::IDX_MAP_ENTRY_SELECTOR, {16'h0, op0});
    wr(frm_pkg::IDX_MAP_ENTRY_CONFIG, {16'h0, op1});
    wr(frm_pkg::IDX_FUNCTION_CODE, code);
  endtask
endmodule

// *** frm_function_request_bench.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module frm_function_request_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, completion_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [4:0]  entry_valid;
  logic        e;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n_irq = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (completion_irq === 1'b1) n_irq++;
  frm_function_request frm_function_request_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .completion_irq(completion_irq), .entry_valid(entry_valid)
  );
  frm_host_model frm_host_model_i (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    frm_host_model_i.xfer(1'b0, idx, 32'h0, v, e);
    `CHK(v, exp)
  endtask
  // poll past busy, then let the completion pulse land
  task automatic done(input logic [15:0] exp, input int irqs);
    int n = 0;
    do begin
      frm_host_model_i.xfer(1'b0, frm_pkg::IDX_FUNCTION_OUTCOME, 32'h0, v, e);
      n++;
    end while ((v === {16'h0, frm_pkg::OUTCOME_BUSY} || v === 32'h0) && n < 20);
    repeat (4) @(posedge pclk);
    `CHK(v, {16'h0, exp})
    `CHK(n_irq, irqs)
  endtask
  task automatic results;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_fail++;
    results();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(frm_pkg::IDX_UNIT_CONTROL, {30'h0, frm_pkg::CTRL_RESET});
    rd(frm_pkg::IDX_FUNCTION_OUTCOME, 32'h0);
    frm_host_model_i.wr(frm_pkg::IDX_SUBRANGE_SIZE_MASK, 32'hFFFF_FFFF);
    rd(frm_pkg::IDX_SUBRANGE_SIZE_MASK, 32'h0000_FFFF);
    frm_host_model_i.wr(frm_pkg::IDX_PROCESS_LIST_BASE, 32'h0000_0100);
    frm_host_model_i.request(16'h0014, 16'h0002, 16'h0001, 32'h0);
    done(frm_pkg::OUTCOME_DONE, 1);
    `CHK(entry_valid, 5'b00100)
    rd(frm_pkg::IDX_PROCESS_SELECTION_OFFSET, 32'h0000_0014);
    rd(frm_pkg::IDX_PROCESS_ENVIRONMENT, 32'h0000_0114);
    frm_host_model_i.request(16'h0014, 16'h0004, 16'h0001, 32'h0);
    done(frm_pkg::OUTCOME_BAD_ENTRY, 2);
    `CHK(entry_valid, 5'b00100)
    frm_host_model_i.wr(frm_pkg::IDX_UNIT_CONTROL, 32'h3);
    frm_host_model_i.request(16'h0014, 16'h0004, 16'h0001, 32'h0);
    done(frm_pkg::OUTCOME_DONE, 3);
    `CHK(entry_valid, 5'b10100)
    // success pulse off, failures still pulse
    frm_host_model_i.wr(frm_pkg::IDX_UNIT_CONTROL, 32'h1);
    frm_host_model_i.request(16'h0014, 16'h0002, 16'h0000, 32'h0);
    done(frm_pkg::OUTCOME_DONE, 3);
    `CHK(entry_valid, 5'b10000)
    frm_host_model_i.request(16'h0014, 16'h0003, 16'h0005, 32'h8);
    done(frm_pkg::OUTCOME_BAD_CODE, 4);
    frm_host_model_i.wr(frm_pkg::IDX_UNIT_CONTROL, 32'h2);
    frm_host_model_i.wr(frm_pkg::IDX_DESCRIPTOR_INDEX, 32'h5);
    frm_host_model_i.wr(frm_pkg::IDX_DESCRIPTOR_DATA, 32'h6);
    frm_host_model_i.wr(frm_pkg::IDX_DESCRIPTOR_INDEX, 32'h3);
    frm_host_model_i.wr(frm_pkg::IDX_DESCRIPTOR_DATA, 32'h11);
    frm_host_model_i.request(16'h0014, 16'h0003, 16'h0005, 32'h8);
    done(frm_pkg::OUTCOME_DONE, 5);
    frm_host_model_i.wr(frm_pkg::IDX_DESCRIPTOR_INDEX, 32'h3);
    rd(frm_pkg::IDX_DESCRIPTOR_DATA, 32'h17);
    frm_host_model_i.request(16'h0014, 16'h0001, 16'h0001, 32'h0000_AB05);
    done(frm_pkg::OUTCOME_BAD_CODE, 6);
    rd(frm_pkg::IDX_FUNCTION_CODE, 32'h0000_0005);
    `CHK(entry_valid, 5'b10000)
    frm_host_model_i.xfer(1'b0, 8'h30, 32'h0, v, e);
    `CHK({e, v}, 33'h1_0000_0000)
    results();
  end
endmodule
